//--- include/temp_alarm_defines.svh
// Constants for the temperature alarm block: offsets, field positions, timing.
// Included by the package and by every design file that decodes registers.
`ifndef TEMP_ALARM_DEFINES_SVH
`define TEMP_ALARM_DEFINES_SVH

`define TA_PTR_W          8
`define TA_OFF_CONFIG     8'h01
`define TA_OFF_UPPER      8'h02
`define TA_OFF_LOWER      8'h03
`define TA_OFF_CRIT       8'h04
`define TA_OFF_TEMP       8'h05

`define TA_CFG_MODE       0
`define TA_CFG_POL        1
`define TA_CFG_BAND       2
`define TA_CFG_EN         3
`define TA_CFG_STAT       4
`define TA_CFG_CLR        5
`define TA_CFG_WLOCK      6
`define TA_CFG_CLOCK      7
`define TA_CFG_SHDN       8
`define TA_CFG_HYS_LO     9
`define TA_CFG_HYS_HI     10

`define TA_FLAG_CRIT      15
`define TA_FLAG_ABOVE     14
`define TA_FLAG_BELOW     13

`define TA_TEMP_MSB       12
`define TA_THR_LSB        2

// Hysteresis in sixteenths of a degree: 0, 1.5, 3 and 6 degrees
`define TA_HYS_0          14'sh0000
`define TA_HYS_1          14'sh0018
`define TA_HYS_2          14'sh0030
`define TA_HYS_3          14'sh0060

`define TA_CONV_MS        125
`define TA_CLK_KHZ        10000
`define TA_HOLDOFF_TICKS  2'h2

`endif

//--- include/temp_alarm_pkg.sv
// Types shared by the temperature alarm block.
// Includes temp_alarm_defines.svh; its own widths are written out as literals.
`include "temp_alarm_defines.svh"

package temp_alarm_pkg;
    typedef logic signed [13:0] temp_ext_t;
    typedef enum logic [1:0] {BAND_CRIT, BAND_UPPER, BAND_LOWER} band_kind_t;
endpackage : temp_alarm_pkg

//--- core/conv_tick.sv
// Conversion period timer: one-cycle tick each result period.
// Assumes a free-running system clock; period is a parameter so it can be shortened.
`timescale 1ns/1ps

module conv_tick #(
    parameter int unsigned PERIOD_CYCLES = 1250000
) (
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    input  wire logic run_in,
    output logic      tick_out
);
    logic [20:0] cnt_r;
    logic [20:0] cnt_nxt;
    logic        tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (run_in) begin
            if (cnt_r == 21'(PERIOD_CYCLES - 1)) begin
                cnt_nxt  = 21'h0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 21'h1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            cnt_r    <= 21'h0;
            tick_out <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            tick_out <= tick_nxt;
        end
    end
endmodule : conv_tick

//--- core/threshold_compare.sv
// One threshold comparator with hysteresis; purely combinational.
// Assumes temperature and threshold in sign-extended sixteenths of a degree.
`timescale 1ns/1ps

module threshold_compare (
    input  wire temp_alarm_pkg::band_kind_t kind_in,
    input  wire temp_alarm_pkg::temp_ext_t  temp_in,
    input  wire temp_alarm_pkg::temp_ext_t  thr_in,
    input  wire temp_alarm_pkg::temp_ext_t  hys_in,
    input  wire logic                       flag_in,
    output logic                            flag_out
);
    temp_alarm_pkg::temp_ext_t rel;

    always_comb begin
        rel      = thr_in - hys_in;
        flag_out = flag_in;
        case (kind_in)
            temp_alarm_pkg::BAND_CRIT: begin
                if (temp_in >= thr_in) flag_out = 1'b1;
                else if (temp_in < rel) flag_out = 1'b0;
            end
            temp_alarm_pkg::BAND_UPPER: begin
                if (temp_in > thr_in) flag_out = 1'b1;
                else if (temp_in <= rel) flag_out = 1'b0;
            end
            default: begin
                if (temp_in < rel) flag_out = 1'b1;
                else if (temp_in >= thr_in) flag_out = 1'b0;
            end
        endcase
    end
endmodule : threshold_compare

//--- core/temp_alarm_event_logic.sv
// Alarm and event logic of a temperature sensor: thresholds, configuration,
// status flags and the open-drain alarm pin.
// Assumes a serial-port engine presents decoded register reads and writes,
// and the converter holds its latest result steady on temp_result_in.
// Functional notes
// - Config bit 0 picks comparator or interrupt style for the alarm.
// - Config bit 2 picks all three thresholds or critical threshold only.
// - Two-bit hysteresis field applies to the critical and upper releases and to the lower set.
// - Two sticky lock bits freeze the window thresholds and critical threshold.
// - Alarm pin floats after reset until the enable bit is set.
// - Polarity bit selects active-high or active-low alarm pin.
// - Status bit reads alarm state; clear bit releases a latched alarm.
// - Style and band bits change only while enable is off or in that write.
// - Alarm asserted at shutdown entry stays asserted throughout shutdown.
// - Temperature reading carries critical, above-window, below-window flags in top bits.
// - At or above critical the alarm behaves as comparator regardless of style.
// - Upper and lower thresholds form a window; crossings trigger the alarm.
// - Window alarm releases by clear bit or by alert-response answer.
// - After a threshold write skip two conversion ticks before comparing.
// - Critical alarm ignores clear and alert answer; releases only below threshold.
// - Comparator style follows temperature only; register accesses leave it alone.
// - Interrupt style latches on each crossing until a clear write or alert-response answer.
// - Cleared alarm reasserts at or above critical; releases at once below critical minus hysteresis.
// - Upper releases at upper minus hysteresis; lower sets below lower minus hysteresis.
// - A new result every 125 ms is the evaluation tick.
// - Alert-response answer releases the alarm in interrupt, active-low use.
`timescale 1ns/1ps
`include "temp_alarm_defines.svh"

module temp_alarm_event_logic #(
    parameter int unsigned CONV_CYCLES = `TA_CONV_MS * `TA_CLK_KHZ
) (
    input  wire logic                 clock_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    input  wire logic [`TA_PTR_W-1:0] reg_ptr_in,
    input  wire logic [15:0]          reg_wdata_in,
    input  wire logic                 ara_done_in,
    input  wire logic [12:0]          temp_result_in,
    output logic [15:0]               reg_rdata_out,
    output logic                      conv_tick_out,
    output logic                      event_out,
    output logic                      event_oe_out
);
    logic        tick;
    logic        mode_r, mode_nxt;
    logic        pol_r, pol_nxt;
    logic        band_r, band_nxt;
    logic        en_r, en_nxt;
    logic        wlock_r, wlock_nxt;
    logic        clock_r, clock_nxt;
    logic        shdn_r, shdn_nxt;
    logic [1:0]  hys_r, hys_nxt;
    logic [10:0] upper_r, upper_nxt;
    logic [10:0] lower_r, lower_nxt;
    logic [10:0] crit_r, crit_nxt;
    logic [12:0] temp_r, temp_nxt;
    logic [2:0]  flag_r, flag_nxt;
    logic        latch_r, latch_nxt;
    logic        alarm_r, alarm_nxt;
    logic [1:0]  hold_r, hold_nxt;
    logic        oe_nxt;
    logic [15:0] rdata_nxt;
    logic        tick_r;

    logic                                 cfg_wr;
    logic                                 thr_wr;
    logic                                 eval;
    logic                                 clr_req;
    logic                                 window_chg;
    logic                                 comp_alarm;
    logic                                 int_alarm;
    logic [2:0]                           flag_new;
    temp_alarm_pkg::temp_ext_t            temp_ext;
    temp_alarm_pkg::temp_ext_t            hys_ext;
    temp_alarm_pkg::temp_ext_t            thr_ext [3];
    temp_alarm_pkg::band_kind_t           kinds   [3];

    // Shutdown stops the converter timer, so nothing is re-evaluated
    conv_tick #(
        .PERIOD_CYCLES (CONV_CYCLES)
    ) u_tick (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .run_in   (!shdn_r),
        .tick_out (tick)
    );

    assign temp_ext = {temp_result_in[`TA_TEMP_MSB], temp_result_in};
    assign kinds[0] = temp_alarm_pkg::BAND_CRIT;
    assign kinds[1] = temp_alarm_pkg::BAND_UPPER;
    assign kinds[2] = temp_alarm_pkg::BAND_LOWER;
    assign thr_ext[0] = {crit_r[10], crit_r, 2'b00};
    assign thr_ext[1] = {upper_r[10], upper_r, 2'b00};
    assign thr_ext[2] = {lower_r[10], lower_r, 2'b00};

    always_comb begin
        case (hys_r)
            2'h0:    hys_ext = `TA_HYS_0;
            2'h1:    hys_ext = `TA_HYS_1;
            2'h2:    hys_ext = `TA_HYS_2;
            default: hys_ext = `TA_HYS_3;
        endcase
    end

    // Flag order: [2] critical, [1] above window, [0] below window
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
            threshold_compare u_cmp (
                .kind_in  (kinds[gi]),
                .temp_in  (temp_ext),
                .thr_in   (thr_ext[gi]),
                .hys_in   (hys_ext),
                .flag_in  (flag_r[2 - gi]),
                .flag_out (flag_new[2 - gi])
            );
        end
    endgenerate

    always_comb begin
        cfg_wr = 1'b0;
        thr_wr = 1'b0;
        if (reg_wr_in && reg_ptr_in == `TA_OFF_CONFIG) begin
            cfg_wr = 1'b1;
        end else if (reg_wr_in && reg_ptr_in == `TA_OFF_UPPER && !wlock_r) begin
            thr_wr = 1'b1;
        end else if (reg_wr_in && reg_ptr_in == `TA_OFF_LOWER && !wlock_r) begin
            thr_wr = 1'b1;
        end else if (reg_wr_in && reg_ptr_in == `TA_OFF_CRIT && !clock_r) begin
            thr_wr = 1'b1;
        end
    end

    // Configuration and thresholds
    always_comb begin
        mode_nxt  = mode_r;
        pol_nxt   = pol_r;
        band_nxt  = band_r;
        en_nxt    = en_r;
        wlock_nxt = wlock_r;
        clock_nxt = clock_r;
        shdn_nxt  = shdn_r;
        hys_nxt   = hys_r;
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        crit_nxt  = crit_r;
        if (cfg_wr) begin
            // Style and band only move while the output is disabled
            if (!en_r) begin
                mode_nxt = reg_wdata_in[`TA_CFG_MODE];
                band_nxt = reg_wdata_in[`TA_CFG_BAND];
            end
            pol_nxt   = reg_wdata_in[`TA_CFG_POL];
            en_nxt    = reg_wdata_in[`TA_CFG_EN];
            // Locks are sticky until reset
            wlock_nxt = wlock_r | reg_wdata_in[`TA_CFG_WLOCK];
            clock_nxt = clock_r | reg_wdata_in[`TA_CFG_CLOCK];
            shdn_nxt  = reg_wdata_in[`TA_CFG_SHDN];
            hys_nxt   = reg_wdata_in[`TA_CFG_HYS_HI:`TA_CFG_HYS_LO];
        end
        if (thr_wr && reg_ptr_in == `TA_OFF_UPPER) begin
            upper_nxt = reg_wdata_in[`TA_TEMP_MSB:`TA_THR_LSB];
        end
        if (thr_wr && reg_ptr_in == `TA_OFF_LOWER) begin
            lower_nxt = reg_wdata_in[`TA_TEMP_MSB:`TA_THR_LSB];
        end
        if (thr_wr && reg_ptr_in == `TA_OFF_CRIT) begin
            crit_nxt = reg_wdata_in[`TA_TEMP_MSB:`TA_THR_LSB];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            mode_r  <= 1'b0;
            pol_r   <= 1'b0;
            band_r  <= 1'b0;
            en_r    <= 1'b0;
            wlock_r <= 1'b0;
            clock_r <= 1'b0;
            shdn_r  <= 1'b0;
            hys_r   <= 2'h0;
            upper_r <= 11'h000;
            lower_r <= 11'h000;
            crit_r  <= 11'h000;
        end else begin
            mode_r  <= mode_nxt;
            pol_r   <= pol_nxt;
            band_r  <= band_nxt;
            en_r    <= en_nxt;
            wlock_r <= wlock_nxt;
            clock_r <= clock_nxt;
            shdn_r  <= shdn_nxt;
            hys_r   <= hys_nxt;
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
            crit_r  <= crit_nxt;
        end
    end

    // Evaluation and alarm state
    always_comb begin
        // A tick right after a write may end a partial period, so wait two
        hold_nxt = hold_r;
        if (thr_wr) begin
            hold_nxt = `TA_HOLDOFF_TICKS;
        end else if (tick && hold_r != 2'h0) begin
            hold_nxt = hold_r - 2'h1;
        end
        eval       = tick && !shdn_r && hold_r == 2'h0 && !thr_wr;
        temp_nxt   = tick ? temp_result_in : temp_r;
        flag_nxt   = eval ? flag_new : flag_r;
        window_chg = eval && !band_r && (flag_new[1:0] != flag_r[1:0]);
        // Alert answer only counts in interrupt style with active-low pin
        clr_req    = (cfg_wr && reg_wdata_in[`TA_CFG_CLR])
                     || (ara_done_in && mode_r && !pol_r);
        latch_nxt  = latch_r;
        if (clr_req && !flag_r[2] && !shdn_r) begin
            latch_nxt = 1'b0;
        end
        if (eval && flag_r[2] && !flag_new[2]) begin
            latch_nxt = 1'b0;
        end
        if (window_chg && mode_r) begin
            latch_nxt = 1'b1;
        end
        // Style and band from the enabling write must reach the pin with it
        comp_alarm = band_nxt ? flag_nxt[2] : |flag_nxt;
        int_alarm  = flag_nxt[2] | (latch_nxt & !band_nxt);
        if (shdn_r) begin
            alarm_nxt = alarm_r;
        end else if (!mode_nxt || flag_nxt[2]) begin
            alarm_nxt = comp_alarm;
        end else begin
            alarm_nxt = int_alarm;
        end
        // Open drain: pull low for asserted-low, or for idle in active-high use
        oe_nxt = en_nxt && (alarm_nxt ^ pol_nxt);
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            hold_r       <= `TA_HOLDOFF_TICKS;
            temp_r       <= 13'h0000;
            flag_r       <= 3'h0;
            latch_r      <= 1'b0;
            alarm_r      <= 1'b0;
            event_oe_out <= 1'b0;
        end else begin
            hold_r       <= hold_nxt;
            temp_r       <= temp_nxt;
            flag_r       <= flag_nxt;
            latch_r      <= latch_nxt;
            alarm_r      <= alarm_nxt;
            event_oe_out <= oe_nxt;
        end
    end

    // Register reads, returned the cycle after the strobe
    always_comb begin
        rdata_nxt = reg_rdata_out;
        if (reg_rd_in) begin
            if (reg_ptr_in == `TA_OFF_CONFIG) begin
                rdata_nxt = {5'h00, hys_r, shdn_r, clock_r, wlock_r, 1'b0,
                             alarm_r, en_r, band_r, pol_r, mode_r};
            end else if (reg_ptr_in == `TA_OFF_UPPER) begin
                rdata_nxt = {3'h0, upper_r, 2'h0};
            end else if (reg_ptr_in == `TA_OFF_LOWER) begin
                rdata_nxt = {3'h0, lower_r, 2'h0};
            end else if (reg_ptr_in == `TA_OFF_CRIT) begin
                rdata_nxt = {3'h0, crit_r, 2'h0};
            end else if (reg_ptr_in == `TA_OFF_TEMP) begin
                rdata_nxt = {flag_r, temp_r};
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 16'h0000;
            tick_r        <= 1'b0;
        end else begin
            reg_rdata_out <= rdata_nxt;
            tick_r        <= tick;
        end
    end

    assign conv_tick_out = tick_r;
    assign event_out     = 1'b0;
endmodule : temp_alarm_event_logic

//--- sim/temp_alarm_checker.sv
// Port checker for the alarm block.
// Assumes registered read data and a registered pin enable.
`timescale 1ns/1ps
`include "temp_alarm_defines.svh"

module temp_alarm_checker #(
    parameter int unsigned CONV_CYCLES = 20
) (
    input wire logic        clock_in,
    input wire logic        rst_b_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_ptr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        ara_done_in,
    input wire logic [12:0] temp_result_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        conv_tick_out,
    input wire logic        event_out,
    input wire logic        event_oe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_cfg_wr;
        reg_wr_in && reg_ptr_in == `TA_OFF_CONFIG;
    endsequence
    sequence s_cfg_rd;
        reg_rd_in && reg_ptr_in == `TA_OFF_CONFIG;
    endsequence

    property p_pin_low;
        event_out == 1'b0;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("alarm pin drives high");
    property p_reset_idle;
        $rose(rst_b_in) |-> !event_oe_out && reg_rdata_out == 16'h0000;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    property p_disable;
        s_cfg_wr ##0 !reg_wdata_in[`TA_CFG_EN] |=> !event_oe_out;
    endproperty
    a_disable: assert property (p_disable) else $error("pin held while disabled");
    property p_clear_reads0;
        s_cfg_rd |=> !reg_rdata_out[`TA_CFG_CLR];
    endproperty
    a_clear_reads0: assert property (p_clear_reads0) else $error("clear bit reads one");
    property p_status_pin;
        s_cfg_rd |=> (reg_rdata_out[3] & (reg_rdata_out[4] ^ reg_rdata_out[1]))
            == $past(event_oe_out);
    endproperty
    a_status_pin: assert property (p_status_pin) else $error("status and pin disagree");
    property p_thr_fmt;
        reg_rd_in && reg_ptr_in inside {`TA_OFF_UPPER, `TA_OFF_LOWER, `TA_OFF_CRIT}
            |=> reg_rdata_out[15:13] == 3'h0 && reg_rdata_out[1:0] == 2'h0;
    endproperty
    a_thr_fmt: assert property (p_thr_fmt) else $error("threshold spare bits set");
    property p_tick_gap;
        conv_tick_out |=> !conv_tick_out [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
    property p_oe_cause;
        $changed(event_oe_out) |-> $past(reg_wr_in) || $past(ara_done_in)
            || conv_tick_out || $past(conv_tick_out);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin moved without cause");
endmodule : temp_alarm_checker

bind temp_alarm_event_logic temp_alarm_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_ptr_in(reg_ptr_in), .reg_wdata_in(reg_wdata_in),
    .ara_done_in(ara_done_in), .temp_result_in(temp_result_in),
    .reg_rdata_out(reg_rdata_out), .conv_tick_out(conv_tick_out),
    .event_out(event_out), .event_oe_out(event_oe_out));

//--- sim/alarm_host_model.sv
// Host side of the alarm line: pull-up and alert-response answer.
// Assumes requests come with the line active low, in interrupt or comparator style.
`timescale 1ns/1ps

module alarm_host_model (
    input  wire logic clock_in,
    input  wire logic oe_in,
    input  wire logic drive_in,
    input  wire logic ara_req_in,
    output logic      pin_out,
    output logic      ara_done_out
);
    assign pin_out = oe_in ? drive_in : 1'b1;
    initial ara_done_out = 1'b0;
    // Answer only a line seen low
    always @(posedge clock_in) begin
        ara_done_out <= ara_req_in && !pin_out;
    end
endmodule : alarm_host_model

//--- sim/temp_alarm_event_logic_bench.sv
// Self-checking bench for the alarm block with a host line model.
// Assumes a shortened conversion period of CONV cycles.
`timescale 1ns/1ps
`include "temp_alarm_defines.svh"

module temp_alarm_event_logic_bench;
    localparam int unsigned CONV = 20;
    logic        clk, rst_b, wr, rd, ara_req, ara_done, tick, drv, oe, pin;
    logic [7:0]  ptr;
    logic [15:0] wdata, rdata;
    logic [12:0] temp;
    int          err_count, samples_checked;
    int          cycles = 0;

    temp_alarm_event_logic #(.CONV_CYCLES(CONV)) dut_u (
        .clock_in(clk), .rst_b_in(rst_b), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_ptr_in(ptr), .reg_wdata_in(wdata), .ara_done_in(ara_done),
        .temp_result_in(temp), .reg_rdata_out(rdata), .conv_tick_out(tick),
        .event_out(drv), .event_oe_out(oe));
    alarm_host_model host_u (
        .clock_in(clk), .oe_in(oe), .drive_in(drv), .ara_req_in(ara_req),
        .pin_out(pin), .ara_done_out(ara_done));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic stop_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wreg(input logic [7:0] p, input logic [15:0] d);
        @(posedge clk);
        ptr <= p;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] p, input logic [15:0] exp);
        @(posedge clk);
        ptr <= p;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check("register", exp, rdata);
    endtask : rreg

    task automatic pin_is(input logic exp);
        @(negedge clk);
        check("alarm pin", {15'h0000, exp}, {15'h0000, pin});
    endtask : pin_is

    // Skip a tick that latched the old value
    task automatic step(input logic [12:0] t, input int n);
        @(posedge clk);
        temp <= t;
        @(posedge clk);
        repeat (n) @(posedge clk iff tick);
    endtask : step

    task automatic ara();
        @(posedge clk);
        ara_req <= 1'b1;
        @(posedge clk);
        ara_req <= 1'b0;
        @(posedge clk);
    endtask : ara

    initial begin
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        ara_req = 1'b0;
        ptr = 8'h00;
        wdata = 16'h0000;
        temp = 13'h0180;
        err_count = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 1; i <= 4; i++) rreg(i[7:0], 16'h0000);
        rreg(8'h07, 16'h0000);
        pin_is(1'b1);
        wreg(`TA_OFF_CRIT, 16'h0300);
        wreg(`TA_OFF_UPPER, 16'he203);
        wreg(`TA_OFF_LOWER, 16'h0100);
        rreg(`TA_OFF_UPPER, 16'h0200);
        step(13'h0180, 3);
        wreg(`TA_OFF_CONFIG, 16'h0009);
        pin_is(1'b1);
        step(13'h0210, 1);
        pin_is(1'b0);
        rreg(`TA_OFF_TEMP, 16'h4210);
        rreg(`TA_OFF_CONFIG, 16'h0019);
        wreg(`TA_OFF_CONFIG, 16'h0029);
        pin_is(1'b1);
        step(13'h0210, 1);
        pin_is(1'b1);
        step(13'h0180, 1);
        pin_is(1'b0);
        ara();
        pin_is(1'b1);
        wreg(`TA_OFF_CRIT, 16'h0300);
        step(13'h0300, 2);
        pin_is(1'b1);
        step(13'h0300, 1);
        pin_is(1'b0);
        rreg(`TA_OFF_TEMP, 16'hc300);
        wreg(`TA_OFF_CONFIG, 16'h0029);
        pin_is(1'b0);
        step(13'h0250, 1);
        pin_is(1'b1);
        wreg(`TA_OFF_CONFIG, 16'h0008);
        rreg(`TA_OFF_CONFIG, 16'h0009);
        wreg(`TA_OFF_CONFIG, 16'h0000);
        wreg(`TA_OFF_CONFIG, 16'h0208);
        pin_is(1'b0);
        wreg(`TA_OFF_CONFIG, 16'h0228);
        pin_is(1'b0);
        ara();
        pin_is(1'b0);
        step(13'h01f0, 1);
        pin_is(1'b0);
        step(13'h01e0, 1);
        pin_is(1'b1);
        step(13'h00f0, 1);
        pin_is(1'b1);
        step(13'h00e0, 1);
        pin_is(1'b0);
        rreg(`TA_OFF_TEMP, 16'h20e0);
        step(13'h0100, 1);
        pin_is(1'b1);
        rreg(`TA_OFF_CONFIG, 16'h0208);
        wreg(`TA_OFF_CONFIG, 16'h020a);
        pin_is(1'b0);
        wreg(`TA_OFF_CONFIG, 16'h0000);
        wreg(`TA_OFF_CONFIG, 16'h000c);
        step(13'h0250, 1);
        pin_is(1'b1);
        step(13'h0300, 1);
        pin_is(1'b0);
        wreg(`TA_OFF_CONFIG, 16'h010c);
        step(13'h0100, 0);
        repeat (3 * CONV) @(posedge clk);
        pin_is(1'b0);
        wreg(`TA_OFF_CONFIG, 16'h000c);
        step(13'h0100, 1);
        pin_is(1'b1);
        // Remaining hysteresis codes: 3 and 6 degrees below the upper bound
        wreg(`TA_OFF_CONFIG, 16'h0000);
        wreg(`TA_OFF_CONFIG, 16'h0408);
        step(13'h0210, 1);
        pin_is(1'b0);
        step(13'h01d8, 1);
        pin_is(1'b0);
        step(13'h01d0, 1);
        pin_is(1'b1);
        wreg(`TA_OFF_CONFIG, 16'h0608);
        step(13'h0210, 1);
        pin_is(1'b0);
        step(13'h01a8, 1);
        pin_is(1'b0);
        step(13'h01a0, 1);
        pin_is(1'b1);
        wreg(`TA_OFF_CONFIG, 16'h0000);
        wreg(`TA_OFF_CONFIG, 16'h00cc);
        wreg(`TA_OFF_UPPER, 16'h0400);
        wreg(`TA_OFF_CRIT, 16'h0500);
        wreg(`TA_OFF_CONFIG, 16'h000c);
        rreg(`TA_OFF_UPPER, 16'h0200);
        rreg(`TA_OFF_CRIT, 16'h0300);
        rreg(`TA_OFF_CONFIG, 16'h00cc);
        stop_test();
    end
endmodule : temp_alarm_event_logic_bench
